// >>> rtl/axis_sync_map.vh
/*
 * register offsets, mode field positions, reset values and timing counts
 * for the axis mode and synchronisation control block.
 * assumes: included by the rtl files of this block only.
 */
`ifndef AXIS_SYNC_MAP_VH
`define AXIS_SYNC_MAP_VH

`define OFS_MODE_PRE 12'h000
`define OFS_INTERP_PRE 12'h004
`define OFS_COMMAND 12'h008
`define OFS_MODE_WORK 12'h00c
`define OFS_INTERP_WORK 12'h010
`define OFS_STATUS 12'h014
`define OFS_AXIS_CTRL 12'h018

`define B_OPCODE_HI 6
`define B_RAMPDOWN_MANUAL 13
`define B_COUNT_START_OVR 14
`define B_SEQ_LO 16
`define B_SEQ_HI 17
`define B_SYNC_LO 18
`define B_SYNC_HI 19
`define B_MASK_LO 20
`define B_MASK_HI 23
`define B_STOP_IN_EN 24
`define B_STOP_OUT_EN 25
`define B_TOPSPD_OFF 26
`define B_DECEL_IN_EN 28
`define B_DECEL_OUT_EN 29

`define MODE_RESET 32'h00000000
`define INTERP_RESET 32'h00000000
`define INTERP_MAX 32'h07ffffff

`define OPC_CONT_LINEAR 7'h62
`define OPC_LINEAR 7'h63

`define SYNC_NOW 2'h0
`define SYNC_EXT 2'h1
`define SYNC_INT 2'h2
`define SYNC_AXES 2'h3

`define CMD_START 8'h01
`define CMD_SYNC_START_A 8'h06
`define CMD_SYNC_START_B 8'h2a
`define CMD_STOP 8'h03

// minimum width of the shared stop pulse driven out, in ns
`define STOP_PULSE_NS 100
`define CLK_PERIOD_NS 10

`endif

// >>> rtl/pin_sync2.v
/*
 * two flip-flop synchroniser for a bundle of asynchronous pin inputs.
 * assumes: single reference clock, asynchronous active-low reset.
 */
module pin_sync2 #(
	parameter WIDTH = 4
) (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// first stage feeds only the second stage
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // pin_sync2

// >>> rtl/axis_mode_sync_control.v
/*
 * per-axis mode, start synchronisation and shared stop/decel control,
 * with an ahb-lite register slave.
 * assumes: one 100 MHz clock; the motion core reports its phase and
 * error stops; shared lines are open-drain, active low, driven outside.
 */
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`include "axis_sync_map.vh"

module axis_mode_sync_control #(
	parameter NUM_AXES = 4
) (
	input wire ref_clk_in,
	input wire rst_n_in,
	// ahb-lite slave
	input wire hsel_in,
	input wire [11:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	output reg [31:0] hrdata_out,
	output reg hreadyout_out,
	output reg hresp_out,
	// pins, asynchronous
	input wire shared_start_line_n_in,
	input wire shared_stop_line_n_in,
	input wire shared_decel_line_n_in,
	input wire count_start_input_in,
	// from the motion core, same clock
	input wire internal_sync_start_in,
	input wire [NUM_AXES-1:0] axis_stopped_in,
	input wire decelerating_in,
	input wire low_speed_const_in,
	input wire error_stop_in,
	input wire motion_done_in,
	// to the motion core and the pins
	output reg motion_start_out,
	output reg start_pending_out,
	output reg decel_stop_req_out,
	output reg decel_req_out,
	output reg count_override_out,
	output reg rampdown_manual_out,
	output reg top_speed_correction_off_out,
	output reg interp_count_valid_out,
	output reg [31:0] interp_count_working_out,
	output reg [1:0] running_sequence_number_out,
	output reg shared_stop_line_oe_out,
	output reg shared_decel_line_oe_out,
	output reg shared_start_line_oe_out
);
	// stop pulse length in clocks, rounded up, and sequencer states
	localparam integer STOP_PULSE_FULL =
		(`STOP_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam [7:0] STOP_PULSE_CYC = STOP_PULSE_FULL[7:0];
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_WAIT = 2'h1;
	localparam [1:0] ST_RUN = 2'h2;

	// bus-visible registers and sequencer state
	reg [31:0] operation_mode_pre_q;
	reg [31:0] interp_count_pre_q;
	reg [31:0] mode_work_q;
	reg [1:0] state_q;
	reg [7:0] stop_cnt_q;
	reg ext_start_cmd_q;
	reg count_armed_q;
	reg wr_pend_q;
	reg [11:0] wr_addr_q;
	reg [31:0] rd_d;
	reg start_now_d;
	// synchronised pins and decoded fields
	wire [3:0] pins_sync;
	wire start_pin;
	wire stop_pin;
	wire decel_pin;
	wire count_pin;
	wire [1:0] sync_sel;
	wire [NUM_AXES-1:0] watch_mask;
	wire [6:0] pre_opcode;
	wire addr_phase;
	wire cmd_wr;
	wire [7:0] cmd;
	wire start_cmd;
	wire abort_cmd;
	wire sync_cmd;
	wire interp_op;
	wire running;
	wire stop_in_en;
	wire stop_out_en;
	wire decel_in_en;
	wire decel_out_en;
	wire count_ovr_en;
	wire error_stop_now;
	wire [31:0] status_word;

	// all asynchronous pins through two flops
	pin_sync2 #(.WIDTH(4)) u_pin_sync (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.pin_in({count_start_input_in, ~shared_decel_line_n_in,
			~shared_stop_line_n_in, ~shared_start_line_n_in}),
		.sync_out(pins_sync)
	);
	assign start_pin = pins_sync[0];
	assign stop_pin = pins_sync[1];
	assign decel_pin = pins_sync[2];
	assign count_pin = pins_sync[3];

	// fields of the pending mode, used while waiting to start
	assign sync_sel = operation_mode_pre_q[`B_SYNC_HI:`B_SYNC_LO];
	assign watch_mask = operation_mode_pre_q[`B_MASK_LO+NUM_AXES-1:`B_MASK_LO];
	assign pre_opcode = operation_mode_pre_q[`B_OPCODE_HI:0];
	assign interp_op = (pre_opcode == `OPC_CONT_LINEAR) ||
		(pre_opcode == `OPC_LINEAR);

	// bus address phase and command write decode
	assign addr_phase = hsel_in && hready_in && htrans_in[1];
	assign cmd_wr = wr_pend_q && (wr_addr_q == `OFS_COMMAND);
	assign cmd = hwdata_in[7:0];

	// commands written to the command register
	assign start_cmd = cmd_wr && (cmd == `CMD_START);
	assign abort_cmd = cmd_wr && (cmd == `CMD_STOP);
	assign sync_cmd = cmd_wr &&
		(cmd == `CMD_SYNC_START_A || cmd == `CMD_SYNC_START_B);

	// fields of the working mode, used while running
	assign running = (state_q == ST_RUN);
	assign stop_in_en = mode_work_q[`B_STOP_IN_EN];
	assign stop_out_en = mode_work_q[`B_STOP_OUT_EN];
	assign decel_in_en = mode_work_q[`B_DECEL_IN_EN];
	assign decel_out_en = mode_work_q[`B_DECEL_OUT_EN];
	assign count_ovr_en = mode_work_q[`B_COUNT_START_OVR];
	assign error_stop_now = running && error_stop_in && stop_out_en;

	// status word: sequence number, line drives, armed flag, state, valid
	assign status_word = {24'h000000, running_sequence_number_out,
		shared_stop_line_oe_out, shared_decel_line_oe_out,
		count_armed_q, state_q, interp_count_valid_out};

	// start condition by sync selection
	always @* begin
		start_now_d = 1'b0;
		case (sync_sel)
			`SYNC_NOW: start_now_d = 1'b1;
			`SYNC_EXT: start_now_d = start_pin || ext_start_cmd_q;
			`SYNC_INT: start_now_d = internal_sync_start_in;
			`SYNC_AXES: start_now_d = &(axis_stopped_in | ~watch_mask);
			default: start_now_d = 1'b0;
		endcase
	end

	// register read mux
	always @* begin
		rd_d = 32'h00000000;
		case (haddr_in)
			`OFS_MODE_PRE: rd_d = operation_mode_pre_q;
			`OFS_INTERP_PRE: rd_d = interp_count_pre_q;
			`OFS_MODE_WORK: rd_d = mode_work_q;
			`OFS_INTERP_WORK: rd_d = interp_count_working_out;
			`OFS_STATUS: rd_d = status_word;
			default: rd_d = 32'h00000000;
		endcase
	end

	// ahb-lite slave: zero wait states, always okay
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
			hrdata_out <= 32'h00000000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			wr_pend_q <= addr_phase && hwrite_in;
			if (addr_phase) begin
				wr_addr_q <= haddr_in;
			end
			// read data stand for the whole data phase
			if (addr_phase && !hwrite_in) begin
				hrdata_out <= rd_d;
			end
		end
	end

	// pre-registers, written at the end of the data phase
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			operation_mode_pre_q <= `MODE_RESET;
			interp_count_pre_q <= `INTERP_RESET;
		end else begin
			if (wr_pend_q && wr_addr_q == `OFS_MODE_PRE) begin
				operation_mode_pre_q <= hwdata_in;
			end
			if (wr_pend_q && wr_addr_q == `OFS_INTERP_PRE) begin
				interp_count_pre_q <= hwdata_in;
			end
		end
	end

	// sync-start command latched while waiting
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ext_start_cmd_q <= 1'b0;
		end else if (sync_cmd) begin
			ext_start_cmd_q <= 1'b1;
		end else if (state_q != ST_WAIT) begin
			ext_start_cmd_q <= 1'b0;
		end
	end

	// start sequencer and working-register copy
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= ST_IDLE;
			mode_work_q <= `MODE_RESET;
			interp_count_working_out <= `INTERP_RESET;
			interp_count_valid_out <= 1'b0;
			motion_start_out <= 1'b0;
			start_pending_out <= 1'b0;
			running_sequence_number_out <= 2'h0;
			rampdown_manual_out <= 1'b0;
			top_speed_correction_off_out <= 1'b0;
		end else begin
			motion_start_out <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (start_cmd) begin
						state_q <= ST_WAIT;
						start_pending_out <= 1'b1;
					end
				end
				ST_WAIT: begin
					if (abort_cmd) begin
						state_q <= ST_IDLE;
						start_pending_out <= 1'b0;
					end else if (start_now_d) begin
						state_q <= ST_RUN;
						start_pending_out <= 1'b0;
						motion_start_out <= 1'b1;
						mode_work_q <= operation_mode_pre_q;
						interp_count_working_out <= interp_count_pre_q;
						interp_count_valid_out <= interp_op;
						running_sequence_number_out <=
							operation_mode_pre_q[`B_SEQ_HI:`B_SEQ_LO];
						rampdown_manual_out <= operation_mode_pre_q[`B_RAMPDOWN_MANUAL];
						top_speed_correction_off_out <= operation_mode_pre_q[`B_TOPSPD_OFF];
					end
				end
				ST_RUN: begin
					if (motion_done_in) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// stretch the stop pulse so other devices catch it
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stop_cnt_q <= 8'h00;
			shared_stop_line_oe_out <= 1'b0;
		end else begin
			if (error_stop_now) begin
				stop_cnt_q <= STOP_PULSE_CYC;
			end else if (stop_cnt_q != 8'h00) begin
				stop_cnt_q <= stop_cnt_q - 8'h01;
			end
			// held from the error edge until the count runs down
			shared_stop_line_oe_out <= error_stop_now || (stop_cnt_q > 8'h01);
		end
	end

	// requests to the core from the shared stop and decel inputs
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			decel_stop_req_out <= 1'b0;
			decel_req_out <= 1'b0;
		end else begin
			decel_stop_req_out <= running && stop_in_en && stop_pin;
			decel_req_out <= running && decel_in_en && decel_pin;
		end
	end

	// drives onto the shared decel and start lines
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shared_decel_line_oe_out <= 1'b0;
			shared_start_line_oe_out <= 1'b0;
		end else begin
			shared_decel_line_oe_out <= running && decel_out_en &&
				(decelerating_in || low_speed_const_in);
			// this axis never drives the shared start line itself
			shared_start_line_oe_out <= 1'b0;
		end
	end

	// count-start override: armed on the input, cleared when the run ends
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_armed_q <= 1'b0;
			count_override_out <= 1'b0;
		end else begin
			if (!running) begin
				count_armed_q <= 1'b0;
			end else if (count_ovr_en && count_pin) begin
				count_armed_q <= 1'b1;
			end
			count_override_out <= running && count_ovr_en &&
				(count_armed_q || count_pin);
		end
	end
endmodule // axis_mode_sync_control

// >>> bench/axis_sync_checker_assertions.sv
/* port checker for the axis mode and sync control block.
   assumes: bound to axis_mode_sync_control, one clock domain. */
module axis_sync_checker (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire hreadyout_out,
	input wire hresp_out,
	input wire motion_start_out,
	input wire start_pending_out,
	input wire decelerating_in,
	input wire low_speed_const_in,
	input wire error_stop_in,
	input wire shared_stop_line_oe_out,
	input wire shared_decel_line_oe_out,
	input wire [1:0] running_sequence_number_out,
	input wire [31:0] interp_count_working_out,
	input wire interp_count_valid_out,
	input wire rampdown_manual_out,
	input wire top_speed_correction_off_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// bus answers at once and okay
	property p_okay; hreadyout_out && !hresp_out; endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
	// start pulse is single and follows a pending start
	property p_pulse; motion_start_out |=> !motion_start_out; endproperty
	a_pulse: assert property (p_pulse) else $error("start pulse too long");
	property p_pend; motion_start_out |-> $past(start_pending_out); endproperty
	a_pend: assert property (p_pend) else $error("start without pending");
	// working copies change only at a start
	property p_copy; $changed({interp_count_working_out, interp_count_valid_out,
		rampdown_manual_out, top_speed_correction_off_out})
		|-> motion_start_out || $past(motion_start_out); endproperty
	a_copy: assert property (p_copy) else $error("working copy outside start");
	property p_seq; $changed(running_sequence_number_out)
		|-> motion_start_out || $past(motion_start_out); endproperty
	a_seq: assert property (p_seq) else $error("sequence number moved");
	// decel line only while slowing
	property p_decel; shared_decel_line_oe_out
		|-> $past(decelerating_in || low_speed_const_in); endproperty
	a_decel: assert property (p_decel) else $error("decel line without slowing");
	// stop line only on error, held for at least 8 clocks
	property p_stop; $rose(shared_stop_line_oe_out) |-> $past(error_stop_in); endproperty
	a_stop: assert property (p_stop) else $error("stop line without error");
	property p_width; $rose(shared_stop_line_oe_out) |-> shared_stop_line_oe_out[*8];
	endproperty
	a_width: assert property (p_width) else $error("stop pulse too short");
endmodule // axis_sync_checker

bind axis_mode_sync_control axis_sync_checker chk_u (.ref_clk_in(ref_clk_in),
	.rst_n_in(rst_n_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
	.motion_start_out(motion_start_out), .start_pending_out(start_pending_out),
	.decelerating_in(decelerating_in), .low_speed_const_in(low_speed_const_in),
	.error_stop_in(error_stop_in), .shared_stop_line_oe_out(shared_stop_line_oe_out),
	.shared_decel_line_oe_out(shared_decel_line_oe_out),
	.running_sequence_number_out(running_sequence_number_out),
	.interp_count_working_out(interp_count_working_out),
	.interp_count_valid_out(interp_count_valid_out),
	.rampdown_manual_out(rampdown_manual_out),
	.top_speed_correction_off_out(top_speed_correction_off_out));

// >>> bench/other_axes.sv
/* other axes on the shared start, stop and decel lines.
   assumes: open-drain lines with pull-ups, pulls commanded by tb. */
module other_axes (
	input wire [2:0] dut_oe_in,
	input wire [2:0] pull_in,
	output wire [2:0] line_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// wired-and with pull-up, any party pulls low
	assign line_n_out = ~(dut_oe_in | pull_in);
endmodule // other_axes

// >>> bench/tb.sv
/* self-checking bench for axis_mode_sync_control.
   assumes: checker bound, other_axes model on the shared lines. */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_in = 0, rst_n_in = 0, hsel = 0, hwrite = 0, icnt = 0, isync = 0;
	logic dec = 0, lsc = 0, err = 0, done = 0, got, en;
	logic [1:0] htrans = 0;
	logic [2:0] pull = 0;
	logic [3:0] stopped = 0;
	logic [11:0] haddr = 0;
	logic [31:0] hwdata = 0, rd, mode, ip, r;
	logic [6:0] ops [3] = '{7'h62, 7'h63, 7'h41};
	wire [31:0] hrdata, icw;
	wire [2:0] oe, ln;
	wire [1:0] seq;
	wire hrdy, hresp, mstart, pend, dsr, drq, covr, rdm, tso, iv;
	int miscompares = 0, total_checks = 0, i;

	axis_mode_sync_control dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
		.hreadyout_out(hrdy), .hresp_out(hresp), .shared_start_line_n_in(ln[2]),
		.shared_stop_line_n_in(ln[1]), .shared_decel_line_n_in(ln[0]),
		.count_start_input_in(icnt), .internal_sync_start_in(isync),
		.axis_stopped_in(stopped), .decelerating_in(dec), .low_speed_const_in(lsc),
		.error_stop_in(err), .motion_done_in(done), .motion_start_out(mstart),
		.start_pending_out(pend), .decel_stop_req_out(dsr), .decel_req_out(drq),
		.count_override_out(covr), .rampdown_manual_out(rdm),
		.top_speed_correction_off_out(tso), .interp_count_valid_out(iv),
		.interp_count_working_out(icw), .running_sequence_number_out(seq),
		.shared_stop_line_oe_out(oe[1]), .shared_decel_line_oe_out(oe[0]),
		.shared_start_line_oe_out(oe[2]));
	other_axes far_u (.dut_oe_in(oe), .pull_in(pull), .line_n_out(ln));

	// clock
	always #5 ref_clk_in = ~ref_clk_in;

	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task stop_test;
		if (miscompares == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one single bus transfer, waits on hready
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk_in); while (hrdy !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk_in); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask

	task wait_start;
		got = 0;
		repeat (8) begin
			@(negedge ref_clk_in);
			if (mstart === 1'b1) got = 1;
		end
	endtask

	function automatic logic exp_valid(input logic [6:0] op);
		exp_valid = (op == 7'h62) || (op == 7'h63);
	endfunction

	// one operation with sync s and axis mask m
	task go(input logic [1:0] s, input logic [3:0] m);
		r = $urandom;
		// enables of count override, stop in/out and decel in/out together
		en = (m == 4'hf) ? !s[0] : r[9];
		mode = {2'h0, en, en, 1'h0, r[0], en, en, m, s, r[2:1], 1'h0, en, r[3], 6'h0,
			ops[r[5:4] == 2'h3 ? 0 : r[5:4]]};
		ip = $urandom & 32'h07ffffff;
		ahb(1, 12'h000, mode);
		ahb(1, 12'h004, ip);
		ahb(0, 12'h000, 0);
		chk(rd, mode);
		ahb(0, 12'h004, 0);
		chk(rd, ip);
		stopped <= m & (m - 4'h1);
		ahb(1, 12'h008, 32'h1);
		wait_start;
		chk(got, s == 2'h0);
		chk(pend, s != 2'h0);
		// abort while waiting, then start again
		if (s != 2'h0 && (r[10] || m == 4'hf)) begin
			ahb(1, 12'h008, 32'h3);
			@(negedge ref_clk_in);
			chk(pend, 0);
			ahb(1, 12'h008, 32'h1);
			@(negedge ref_clk_in);
			chk({pend, mstart}, 2'h2);
		end
		@(posedge ref_clk_in);
		if (s == 2'h1 && r[6]) pull[2] <= 1;
		if (s == 2'h1 && !r[6]) ahb(1, 12'h008, r[7] ? 32'h6 : 32'h2a);
		isync <= (s == 2'h2);
		stopped <= m;
		if (s != 2'h0) wait_start;
		chk(got, 1);
		chk(icw, ip);
		chk(iv, exp_valid(mode[6:0]));
		chk({seq, rdm, tso}, {r[2:1], r[3], r[0]});
		ahb(0, 12'h014, 0);
		chk(rd, {24'h0, r[2:1], 3'h0, 2'h2, exp_valid(mode[6:0])});
		ahb(0, 12'h00c, 0);
		chk(rd, mode);
		@(posedge ref_clk_in);
		pull <= 3'h3;
		isync <= 0;
		dec <= r[8];
		lsc <= !r[8];
		icnt <= 1;
		repeat (5) @(negedge ref_clk_in);
		chk({oe[0], drq, dsr, covr, ln[0]}, {en, en, en, en, 1'b0});
		@(posedge ref_clk_in);
		pull <= 3'h1;
		err <= 1;
		@(posedge ref_clk_in);
		err <= 0;
		repeat (3) @(negedge ref_clk_in);
		chk({oe[1], ln[1]}, {en, !en});
		@(posedge ref_clk_in);
		done <= 1;
		pull <= 0;
		dec <= 0;
		lsc <= 0;
		icnt <= 0;
		@(posedge ref_clk_in);
		done <= 0;
		repeat (14) @(negedge ref_clk_in);
		chk({oe, pend}, 4'h0);
	endtask

	// reset, register defaults, then every sync mode twice
	initial begin
		void'($urandom(81628));
		repeat (6) @(posedge ref_clk_in);
		rst_n_in <= 1;
		ahb(0, 12'h000, 0);
		chk(rd, 32'h0);
		ahb(0, 12'h018, 0);
		chk(rd, 32'h0);
		for (i = 0; i < 8; i++) go(i[1:0], (i < 4) ? 4'hf : 4'h5 + i[3:0]);
		stop_test;
	end

	// watchdog
	initial begin
		#200us;
		miscompares++;
		stop_test;
	end
endmodule // tb
